// ===== rtl/pwm_timer_ctrl.sv
// control registers of the pwm timer: main control, secondary control views, busy status
// assumes a single-cycle register port on ref_clk and level inputs from outside the domain
`timescale 1ns/1ps
`default_nettype none
module pwm_timer_ctrl
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire pwm_timer_pkg::reg_req_t bus_req,
    output logic [31:0] rd_data,
    input wire logic ovf_evt,
    input wire logic retrig_evt,
    input wire logic standby_req,
    input wire logic access_protect,
    output logic [3:0] capture_select,
    output logic update_lock,
    output logic count_down,
    output logic oneshot_mode,
    output logic timer_running,
    output logic count_tick,
    output logic counter_reload,
    output logic [2:0] dither_bits
);
    import pwm_timer_pkg::*;

    logic [3:0] cap_ff;
    logic auto_lock_ff;
    logic [1:0] rsel_ff;
    logic stdby_ff;
    logic [2:0] div_code_ff;
    logic [1:0] res_ff;
    logic enable_ff;
    logic sw_reset_ff;
    logic [2:0] cmd_ff;
    logic [1:0] idx_ff;
    logic oneshot_ff;
    logic lock_ff;
    logic dir_ff;
    logic en_busy_ff;
    logic reload_pend_ff;
    logic [31:0] rd_data_ff;
    logic running_ff;
    logic tick_ff;
    logic reload_ff;
    logic [2:0] dith_ff;

    logic [3:0] sync_in;
    logic [3:0] sync_out;
    logic timer_on;
    logic rst_sync;
    logic prot_q;
    logic stdby_q;

    // enable, reset, access protect and standby cross; field bits act directly
    assign sync_in = {standby_req, access_protect, sw_reset_ff, enable_ff};
    generate
        for (genvar i = 0; i < 4; i++)
        begin : g_sync
            level_sync3 u_sync
            (
                .ref_clk(ref_clk),
                .resetn(resetn),
                .din(sync_in[i]),
                .dout(sync_out[i])
            );
        end
    endgenerate
    assign timer_on = sync_out[0];
    assign rst_sync = sync_out[1];
    assign prot_q = sync_out[2];
    assign stdby_q = sync_out[3];

    // address decode on word boundaries; lanes pick the byte
    wire main_sel = (bus_req.addr[7:2] == ADDR_MAIN[7:2]);
    wire sec_sel = (bus_req.addr[7:2] == ADDR_SEC_CLR[7:2]);
    wire busy_sel = (bus_req.addr[7:2] == ADDR_BUSY[7:2]);
    wire wr_ok = bus_req.wr && !prot_q;
    wire [31:0] wd = bus_req.wdata;
    wire [3:0] be = bus_req.be;
    wire sw_reset_hit = wr_ok && main_sel && be[0] && wd[RST_BIT];
    wire main_wr = wr_ok && main_sel && !sw_reset_hit;
    wire cfg_wr = main_wr && !enable_ff && !timer_on;
    wire en_wr = main_wr && be[0];
    // both lanes of the same word reach one store
    wire clr_wr = wr_ok && sec_sel && be[ADDR_SEC_CLR[1:0]];
    wire set_wr = wr_ok && sec_sel && be[ADDR_SEC_SET[1:0]];
    wire [7:0] clr_b = wd[8*ADDR_SEC_CLR[1:0] +: 8];
    wire [7:0] set_b = wd[8*ADDR_SEC_SET[1:0] +: 8];
    // reset completes once it has crossed
    wire soft_clr = rst_sync && sw_reset_ff;

    wire tick = tick_ff;
    // reserved code behaves as plain timer-clock reload
    wire [1:0] eff_sel = (rsel_ff == RSEL_RESERVED) ? RSEL_TIMER_CLK : rsel_ff;
    wire cmd_exec = (cmd_ff != CMD_NONE) && tick && timer_on;
    wire retrig = timer_on && (retrig_evt || (cmd_exec && cmd_ff == CMD_RETRIGGER));
    wire lock_evt = auto_lock_ff && timer_on && (ovf_evt || retrig);
    // divider clear only for code 2
    wire div_clr = retrig && (eff_sel == RSEL_CLR_DIVIDER);
    wire run_now = timer_on && (!stdby_q || stdby_ff);
    wire div_tick;

    clock_divider u_div
    (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .run(run_now),
        .clear(div_clr || soft_clr),
        .div_sel(div_code_ff),
        .tick(div_tick)
    );

    logic [7:0] nxt_sec;
    logic [7:0] sec_cur;
    assign sec_cur = {cmd_ff, idx_ff, oneshot_ff, lock_ff, dir_ff};

    // clear view first, then set view, hardware set last
    always_comb
    begin
        nxt_sec = sec_cur;
        if (clr_wr)
        begin
            nxt_sec[2:0] = sec_cur[2:0] & ~clr_b[2:0];
            if (clr_b[IDX_LSB +: 2] != 2'h0)
                nxt_sec[IDX_LSB +: 2] = 2'h0;
            if (clr_b[CMD_LSB +: 3] != 3'h0)
                nxt_sec[CMD_LSB +: 3] = CMD_NONE;
        end
        if (cmd_exec)
            nxt_sec[CMD_LSB +: 3] = CMD_NONE;
        if (set_wr)
        begin
            nxt_sec[2:0] = nxt_sec[2:0] | set_b[2:0];
            if (set_b[IDX_LSB +: 2] != 2'h0)
                nxt_sec[IDX_LSB +: 2] = set_b[IDX_LSB +: 2];
            if (set_b[CMD_LSB +: 3] != 3'h0)
                nxt_sec[CMD_LSB +: 3] = set_b[CMD_LSB +: 3];
        end
        // event set beats a same-cycle clear
        if (lock_evt)
            nxt_sec[LOCK_BIT] = 1'b1;
    end

    // software reset clears every register here
    always_ff @(posedge ref_clk)
    begin
        if (!resetn || soft_clr)
        begin
            {cap_ff, auto_lock_ff, rsel_ff, stdby_ff, div_code_ff, res_ff} <= 13'h0000;
            enable_ff <= MAIN_RST[EN_BIT];
            {cmd_ff, idx_ff, oneshot_ff, lock_ff, dir_ff} <= SEC_RST;
            en_busy_ff <= 1'b0;
        end
        else
        begin
            if (cfg_wr && be[3])
                cap_ff <= wd[CAP_LSB +: 4];
            if (cfg_wr && be[1])
            begin
                auto_lock_ff <= wd[AUTO_LOCK_BIT];
                rsel_ff <= wd[RSEL_LSB +: 2];
                stdby_ff <= wd[STDBY_BIT];
                div_code_ff <= wd[DIV_CODE_LSB +: 3];
            end
            if (cfg_wr && be[0])
                res_ff <= wd[RES_LSB +: 2];
            if (en_wr)
                enable_ff <= wd[EN_BIT];
            if (en_wr)
                en_busy_ff <= 1'b1;
            else if (timer_on == enable_ff)
                en_busy_ff <= 1'b0;
            {cmd_ff, idx_ff, oneshot_ff, lock_ff, dir_ff} <= nxt_sec;
        end
    end

    // reset bit doubles as its busy flag
    // a new reset request beats the clear of the one that is finishing
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            sw_reset_ff <= MAIN_RST[RST_BIT];
        else if (sw_reset_hit)
            sw_reset_ff <= 1'b1;
        else if (soft_clr)
            sw_reset_ff <= MAIN_RST[RST_BIT];
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn || soft_clr)
        begin
            reload_pend_ff <= 1'b0;
            reload_ff <= 1'b0;
        end
        else
        begin
            reload_ff <= (retrig && eff_sel != RSEL_DIVIDED) || (reload_pend_ff && tick);
            if (retrig && eff_sel == RSEL_DIVIDED)
                reload_pend_ff <= 1'b1;
            else if (tick)
                reload_pend_ff <= 1'b0;
        end
    end

    // one-cycle read answer for any width
    wire [31:0] main_rd = {4'h0, cap_ff, 9'h000, auto_lock_ff, rsel_ff, stdby_ff, div_code_ff,
                           1'b0, res_ff, 3'h0, enable_ff, sw_reset_ff};
    wire [31:0] sec_rd = {16'h0000, sec_cur, sec_cur};
    wire [31:0] busy_rd = {30'h00000000, en_busy_ff, sw_reset_ff};
    // lanes outside the enables read as zero
    wire [31:0] lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    wire [31:0] rd_sel = main_sel ? main_rd : sec_sel ? sec_rd : busy_sel ? busy_rd : 32'h0;

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            rd_data_ff <= 32'h00000000;
            running_ff <= 1'b0;
            tick_ff <= 1'b0;
            dith_ff <= 3'h0;
        end
        else
        begin
            rd_data_ff <= bus_req.rd ? (rd_sel & lane_mask) : 32'h00000000;
            running_ff <= run_now;
            tick_ff <= div_tick;
            dith_ff <= DITH_BITS[res_ff];
        end
    end

    assign rd_data = rd_data_ff;
    assign capture_select = cap_ff;
    assign update_lock = lock_ff;
    assign count_down = dir_ff;
    assign oneshot_mode = oneshot_ff;
    assign timer_running = running_ff;
    assign count_tick = tick_ff;
    assign counter_reload = reload_ff;
    assign dither_bits = dith_ff;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence reset_write_s;
        sw_reset_hit;
    endsequence
    sequence reset_done_s;
        ##[1:12] (!sw_reset_ff && !busy_rd[0]);
    endsequence

    reset_wins_a: assert property (
        reset_write_s |=> sw_reset_ff && $stable(div_code_ff))
        else $error("reset write let other bits through");
    reset_ends_a: assert property (
        reset_write_s ##1 !sw_reset_hit |-> reset_done_s)
        else $error("software reset never completed");
    enable_guard_a: assert property (
        main_wr && be[1] && enable_ff |=> $stable(div_code_ff))
        else $error("guarded field changed while enabled");
    protect_drop_a: assert property (bus_req.wr && prot_q |=> $stable(sec_cur))
        else $error("protected write changed secondary control");
    auto_lock_a: assert property (lock_evt |=> lock_ff)
        else $error("auto lock did not set the update lock");
    en_busy_a: assert property (en_wr |=> en_busy_ff && enable_ff == $past(wd[EN_BIT]))
        else $error("enable write not shown at once with busy");
    reload_next_a: assert property (retrig && eff_sel == RSEL_TIMER_CLK |=> reload_ff)
        else $error("retrigger reload missed next clock");
    clear_view_a: assert property (clr_wr && clr_b[DIR_BIT] && !set_wr |=> !dir_ff)
        else $error("clear view did not clear direction");
    rd_busy_a: assert property (
        bus_req.rd && busy_sel && be[0] |=> rd_data[0] == $past(sw_reset_ff))
        else $error("busy read mismatch");
endmodule : pwm_timer_ctrl
`default_nettype wire

// ===== rtl/pwm_timer_pkg.sv
// constants, codes and bus carrier for the pwm timer control registers
// assumes one 100 MHz timer clock and a byte-addressed register port
package pwm_timer_pkg;

    // register byte addresses; the secondary control word holds clear (lane 0) and set (lane 1)
    localparam logic [7:0] ADDR_MAIN = 8'h00;
    localparam logic [7:0] ADDR_SEC_CLR = 8'h04;
    localparam logic [7:0] ADDR_SEC_SET = 8'h05;
    localparam logic [7:0] ADDR_BUSY = 8'h08;

    // main_control fields
    localparam int CAP_LSB = 24;
    localparam int AUTO_LOCK_BIT = 14;
    localparam int RSEL_LSB = 12;
    localparam int STDBY_BIT = 11;
    localparam int DIV_CODE_LSB = 8;
    localparam int RES_LSB = 5;
    localparam int EN_BIT = 1;
    localparam int RST_BIT = 0;

    // secondary_control fields
    localparam int CMD_LSB = 5;
    localparam int IDX_LSB = 3;
    localparam int ONESHOT_BIT = 2;
    localparam int LOCK_BIT = 1;
    localparam int DIR_BIT = 0;

    localparam logic [31:0] MAIN_RST = 32'h00000000;
    localparam logic [7:0] SEC_RST = 8'h00;

    localparam logic [2:0] CMD_NONE = 3'h0;
    localparam logic [2:0] CMD_RETRIGGER = 3'h1;

    localparam logic [1:0] RSEL_TIMER_CLK = 2'h0;
    localparam logic [1:0] RSEL_DIVIDED = 2'h1;
    localparam logic [1:0] RSEL_CLR_DIVIDER = 2'h2;
    localparam logic [1:0] RSEL_RESERVED = 2'h3;

    // terminal counts of the divider for codes 0..7 (divide by 1..1024)
    localparam logic [9:0] DIV_LIMIT [0:7] = '{10'h000, 10'h001, 10'h003, 10'h007,
                                              10'h00F, 10'h03F, 10'h0FF, 10'h3FF};
    // pattern bits used by dithering for resolution codes 0..3
    localparam logic [2:0] DITH_BITS [0:3] = '{3'h0, 3'h4, 3'h5, 3'h6};

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage : pwm_timer_pkg

// ===== rtl/level_sync3.sv
// three-stage level synchroniser with agreement filter
// assumes the input may change at any time relative to ref_clk
`timescale 1ns/1ps
`default_nettype none
module level_sync3
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic din,
    output logic dout
);
    import pwm_timer_pkg::*;

    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic out_ff;

    // the first stage feeds only the second; the output moves once stages two and three agree
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
            out_ff <= 1'b0;
        end
        else
        begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff)
                out_ff <= s3_ff;
        end
    end

    assign dout = out_ff;
endmodule : level_sync3
`default_nettype wire

// ===== rtl/clock_divider.sv
// prescaler: free-running divider with a one-cycle tick at the selected ratio
// assumes clear and run come from logic on ref_clk
`timescale 1ns/1ps
`default_nettype none
module clock_divider
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic run,
    input wire logic clear,
    input wire logic [2:0] div_sel,
    output logic tick
);
    import pwm_timer_pkg::*;

    logic [9:0] cnt_ff;
    logic tick_ff;
    logic [9:0] limit;
    logic at_limit;

    assign limit = DIV_LIMIT[div_sel];
    // a ratio change can leave the count above the new limit, so wrap on >=
    assign at_limit = (cnt_ff >= limit);

    always_ff @(posedge ref_clk)
    begin
        if (!resetn || clear)
        begin
            cnt_ff <= 10'h000;
            tick_ff <= 1'b0;
        end
        else
        begin
            tick_ff <= run && at_limit;
            if (run)
                cnt_ff <= at_limit ? 10'h000 : cnt_ff + 10'h001;
        end
    end

    assign tick = tick_ff;
endmodule : clock_divider
`default_nettype wire

// ===== test/pwm_timer_ctrl_tb.sv
// self-checking bench for the pwm timer control registers
// assumes rtl/ is compiled first; the bench drives every port with no partner model
`timescale 1ns/1ps
`default_nettype none
module pwm_timer_ctrl_tb;
    import pwm_timer_pkg::*;
    logic ref_clk;
    logic resetn;
    reg_req_t bus_req;
    logic [31:0] rd_data;
    logic ovf_evt;
    logic retrig_evt;
    logic standby_req;
    logic access_protect;
    logic [3:0] capture_select;
    logic update_lock;
    logic count_down;
    logic oneshot_mode;
    logic timer_running;
    logic count_tick;
    logic counter_reload;
    logic [2:0] dither_bits;
    int fail_count;
    int tests_run;
    int div_tab [0:7] = '{1, 2, 4, 8, 16, 64, 256, 1024};
    logic [31:0] v;
    logic [31:0] w;
    logic seen;
    int n;

    pwm_timer_ctrl u_dut
    (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .bus_req(bus_req),
        .rd_data(rd_data),
        .ovf_evt(ovf_evt),
        .retrig_evt(retrig_evt),
        .standby_req(standby_req),
        .access_protect(access_protect),
        .capture_select(capture_select),
        .update_lock(update_lock),
        .count_down(count_down),
        .oneshot_mode(oneshot_mode),
        .timer_running(timer_running),
        .count_tick(count_tick),
        .counter_reload(counter_reload),
        .dither_bits(dither_bits)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict

    task automatic check(input string name, input logic [31:0] seen_v, input logic [31:0] exp);
        tests_run++;
        if (seen_v !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen_v);
        end
    endtask : check

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: d, be: b, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input logic [3:0] b, output logic [31:0] d);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: 32'h0, be: b, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        #1;
        d = rd_data;
    endtask : reg_rd

    task automatic expect_reg(input string name, input logic [7:0] a, input logic [3:0] b,
                              input logic [31:0] exp);
        logic [31:0] d;
        reg_rd(a, b, d);
        check(name, d, exp);
    endtask : expect_reg

    // bounded poll of the busy status; a hang shows as a mismatch
    task automatic wait_idle;
        logic [31:0] d;
        int k;
        k = 0;
        d = 32'hFFFFFFFF;
        while (d !== 32'h0 && k < 40)
        begin
            reg_rd(ADDR_BUSY, 4'hF, d);
            k++;
        end
        check("busy clear", d, 32'h0);
    endtask : wait_idle

    // guarded fields only move while disabled, so drop enable first
    task automatic set_cfg(input logic [31:0] c);
        reg_wr(ADDR_MAIN, 32'h0, 4'h1);
        wait_idle();
        reg_wr(ADDR_MAIN, c & 32'hFFFFFFFC, 4'hF);
        reg_wr(ADDR_MAIN, 32'h2, 4'h1);
        wait_idle();
    endtask : set_cfg

    task automatic evt_pulse(input bit retrig, output logic s);
        @(posedge ref_clk);
        if (retrig)
            retrig_evt <= 1'b1;
        else
            ovf_evt <= 1'b1;
        s = 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            @(posedge ref_clk);
            ovf_evt <= 1'b0;
            retrig_evt <= 1'b0;
            #1;
            if (counter_reload === 1'b1)
                s = 1'b1;
        end
    endtask : evt_pulse

    task automatic tick_gap(output int g);
        int k;
        k = 0;
        while (count_tick !== 1'b1 && k < 3000)
        begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        @(posedge ref_clk);
        #1;
        g = 1;
        while (count_tick !== 1'b1 && g < 3000)
        begin
            @(posedge ref_clk);
            #1;
            g++;
        end
    endtask : tick_gap

    // worst case is the divide-by-1024 sweep, well under this span
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        fail_count++;
        give_verdict();
    end

    initial
    begin
        fail_count = 0;
        tests_run = 0;
        resetn = 1'b0;
        bus_req = '0;
        ovf_evt = 1'b0;
        retrig_evt = 1'b0;
        standby_req = 1'b0;
        access_protect = 1'b0;
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        expect_reg("main reset", ADDR_MAIN, 4'hF, MAIN_RST);
        expect_reg("sec reset", ADDR_SEC_CLR, 4'h3, {16'h0, SEC_RST, SEC_RST});
        expect_reg("busy reset", ADDR_BUSY, 4'hF, 32'h0);
        reg_wr(ADDR_MAIN, 32'h0A000000, 4'h8);
        reg_wr(ADDR_MAIN, 32'h00000700, 4'h2);
        expect_reg("main lane1", ADDR_MAIN, 4'h2, 32'h00000700);
        // the halfword write replaces all of lane 1, divider code included
        reg_wr(ADDR_MAIN, 32'h00006040, 4'h3);
        expect_reg("main word", ADDR_MAIN, 4'hF, 32'h0A006040);
        expect_reg("main lane3", ADDR_MAIN, 4'h8, 32'h0A000000);
        expect_reg("main low half", ADDR_MAIN, 4'h3, 32'h00006040);
        check("capture out", {28'h0, capture_select}, 32'hA);
        access_protect <= 1'b1;
        repeat (8) @(posedge ref_clk);
        reg_wr(ADDR_MAIN, 32'h05000000, 4'h8);
        reg_wr(ADDR_SEC_CLR, 32'h00000100, 4'h2);
        expect_reg("protected main", ADDR_MAIN, 4'hF, 32'h0A006040);
        expect_reg("protected sec", ADDR_SEC_CLR, 4'h3, 32'h0);
        access_protect <= 1'b0;
        repeat (8) @(posedge ref_clk);
        for (int r = 0; r < 4; r++)
        begin
            reg_wr(ADDR_MAIN, 32'(r << RES_LSB), 4'h1);
            repeat (3) @(posedge ref_clk);
            check("dither", {29'h0, dither_bits}, (r == 0) ? 32'h0 : 32'(r + 3));
        end
        reg_wr(ADDR_MAIN, 32'h00000062, 4'h1);
        expect_reg("enable busy", ADDR_BUSY, 4'hF, 32'h2);
        expect_reg("enable readback", ADDR_MAIN, 4'h1, 32'h62);
        wait_idle();
        repeat (2) @(posedge ref_clk);
        check("running", {31'h0, timer_running}, 32'h1);
        reg_wr(ADDR_MAIN, 32'h0F000700, 4'hA);
        // let the register update of that edge settle before looking
        #1;
        check("capture guarded", {28'h0, capture_select}, 32'hA);
        expect_reg("divider guarded", ADDR_MAIN, 4'h2, 32'h00006000);
        for (int c = 0; c < 8; c++)
        begin
            set_cfg(32'(c << DIV_CODE_LSB));
            tick_gap(n);
            check("tick gap", 32'(n), 32'(div_tab[c]));
        end
        set_cfg(32'h1 << AUTO_LOCK_BIT);
        evt_pulse(1'b0, seen);
        check("lock on ovf", {31'h0, update_lock}, 32'h1);
        reg_wr(ADDR_SEC_CLR, 32'h00000002, 4'h1);
        expect_reg("sec cleared", ADDR_SEC_CLR, 4'h3, 32'h0);
        check("lock cleared", {31'h0, update_lock}, 32'h0);
        reg_wr(ADDR_SEC_CLR, 32'h00000500, 4'h2);
        reg_wr(ADDR_SEC_CLR, 32'h00000000, 4'h2);
        expect_reg("sec set", ADDR_SEC_CLR, 4'h3, 32'h0505);
        check("set outputs", {30'h0, oneshot_mode, count_down}, 32'h3);
        reg_wr(ADDR_SEC_CLR, 32'h00000001, 4'h1);
        expect_reg("sec clear dir", ADDR_SEC_CLR, 4'h1, 32'h04);
        evt_pulse(1'b1, seen);
        check("lock on retrig", {31'h0, update_lock}, 32'h1);
        // a queued retrigger command runs on the next tick, reads back zero and locks
        reg_wr(ADDR_SEC_CLR, 32'h00000002, 4'h1);
        reg_wr(ADDR_SEC_CLR, 32'h00002000, 4'h2);
        expect_reg("command done", ADDR_SEC_CLR, 4'h1, 32'h06);
        check("lock on command", {31'h0, update_lock}, 32'h1);
        for (int s = 0; s < 4; s++)
        begin
            set_cfg(32'(s << RSEL_LSB));
            reg_wr(ADDR_SEC_CLR, 32'h00000002, 4'h1);
            evt_pulse(1'b0, seen);
            check("no auto lock", {31'h0, update_lock}, 32'h0);
            evt_pulse(1'b1, seen);
            check("reload", {31'h0, seen}, 32'h1);
        end
        set_cfg(32'h0);
        standby_req <= 1'b1;
        repeat (8) @(posedge ref_clk);
        check("halt standby", {31'h0, timer_running}, 32'h0);
        set_cfg(32'h1 << STDBY_BIT);
        repeat (8) @(posedge ref_clk);
        check("run standby", {31'h0, timer_running}, 32'h1);
        standby_req <= 1'b0;
        reg_wr(ADDR_MAIN, 32'h0A000000, 4'h8);
        set_cfg(32'h0A000000);
        // reset write then two reads with no gap, both inside the reset window
        @(posedge ref_clk);
        bus_req <= '{addr: ADDR_MAIN, wdata: 32'h05004001, be: 4'hF, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus_req <= '{addr: ADDR_MAIN, wdata: 32'h0, be: 4'hF, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus_req.addr <= ADDR_BUSY;
        #1;
        v = rd_data;
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        #1;
        w = rd_data;
        check("reset wins", v & 32'h0F004001, 32'h0A000001);
        check("reset busy", w & 32'h1, 32'h1);
        wait_idle();
        expect_reg("main after reset", ADDR_MAIN, 4'hF, MAIN_RST);
        expect_reg("sec after reset", ADDR_SEC_CLR, 4'h3, 32'h0);
        repeat (2) @(posedge ref_clk);
        check("stopped", {31'h0, timer_running}, 32'h0);
        give_verdict();
    end
endmodule : pwm_timer_ctrl_tb
`default_nettype wire
